// ===== fobr_pkg.sv
// package: offsets, reset values and scaling constants of the observation bank
package fobr_pkg;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned FRAC_BITS  = 27;
  localparam int unsigned NUM_REGS   = 7;
  localparam int unsigned SEL_W      = 3;
  // register offsets in 16-bit address units
  localparam logic [ADDR_W-1:0] OFS_ALPHA_I = 12'h4d2;
  localparam logic [ADDR_W-1:0] OFS_BETA_I  = 12'h4d4;
  localparam logic [ADDR_W-1:0] OFS_ALPHA_V = 12'h4d6;
  localparam logic [ADDR_W-1:0] OFS_BETA_V  = 12'h4d8;
  localparam logic [ADDR_W-1:0] OFS_D_I     = 12'h4e2;
  localparam logic [ADDR_W-1:0] OFS_Q_I     = 12'h4e4;
  localparam logic [ADDR_W-1:0] OFS_D_V     = 12'h4e6;
  localparam logic [ADDR_W-1:0] OFS_STEP    = 12'h002;
  localparam logic [DATA_W-1:0] RST_VAL     = 32'h0000_0000;
  localparam logic [DATA_W-1:0] UNMAPPED    = 32'h0000_0000;
  typedef enum logic [SEL_W-1:0] {
    SEL_ALPHA_I, SEL_BETA_I, SEL_ALPHA_V, SEL_BETA_V, SEL_D_I, SEL_Q_I, SEL_D_V
  } fobr_sel_e;
endpackage

// ===== fobr_obs_reg.sv
// one read-only observation word loaded only by the control loop
`timescale 1ns/1ps
module fobr_obs_reg
(
  input  wire logic                        CLK_I,
  input  wire logic                        RST_I,
  input  wire logic                        load_i,
  input  wire logic [fobr_pkg::DATA_W-1:0] data_i,
  output logic      [fobr_pkg::DATA_W-1:0] q_o
);
  import fobr_pkg::*;

  logic [DATA_W-1:0] val_r;
  logic [DATA_W-1:0] val_nxt;

  always_comb begin
    val_nxt = val_r;
    if (load_i) begin
      val_nxt = data_i;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      val_r <= RST_VAL;
    end else begin
      val_r <= val_nxt;
    end
  end

  assign q_o = val_r;
endmodule

// ===== fobr_obs_bank.sv
// top of the field-oriented control observation register bank
// How it works
// - alpha current word is signed Q27, scaled by base current over eight.
// - beta current word is signed Q27, scaled by base current over eight.
// - alpha voltage word is signed Q27, scaled by sixty over root three.
// - beta voltage word is signed Q27, scaled by sixty over root three.
// - d-axis current word is signed Q27, base current over eight.
// - q-axis current word is signed Q27, base current over eight.
// - negative values use full-width two's complement.
// - every observation word reads zero after reset until loaded.
// - beta voltage sits two address units above alpha voltage.
// - d current, q current, d voltage ascend two units apart.
// - d-axis voltage word is signed Q27, sixty over root three.
`timescale 1ns/1ps
module fobr_obs_bank
(
  input  wire logic                          CLK_I,
  input  wire logic                          RST_I,
  input  wire logic [fobr_pkg::NUM_REGS-1:0] LOAD_I,
  input  wire logic [fobr_pkg::DATA_W-1:0]   ALPHA_I_I,
  input  wire logic [fobr_pkg::DATA_W-1:0]   BETA_I_I,
  input  wire logic [fobr_pkg::DATA_W-1:0]   ALPHA_V_I,
  input  wire logic [fobr_pkg::DATA_W-1:0]   BETA_V_I,
  input  wire logic [fobr_pkg::DATA_W-1:0]   D_I_I,
  input  wire logic [fobr_pkg::DATA_W-1:0]   Q_I_I,
  input  wire logic [fobr_pkg::DATA_W-1:0]   D_V_I,
  input  wire logic                          RD_I,
  input  wire logic                          WR_I,
  input  wire logic [fobr_pkg::ADDR_W-1:0]   ADDR_I,
  input  wire logic [fobr_pkg::DATA_W-1:0]   WDATA_I,
  output logic      [fobr_pkg::DATA_W-1:0]   RDATA_O,
  output logic                               RVALID_O,
  output logic                               HIT_O
);
  import fobr_pkg::*;

  // ************************************************************
  // observation storage
  // ************************************************************
  logic [DATA_W-1:0] in_w  [NUM_REGS];
  logic [DATA_W-1:0] obs_w [NUM_REGS];

  assign in_w[SEL_ALPHA_I] = ALPHA_I_I;
  assign in_w[SEL_BETA_I]  = BETA_I_I;
  assign in_w[SEL_ALPHA_V] = ALPHA_V_I;
  assign in_w[SEL_BETA_V]  = BETA_V_I;
  assign in_w[SEL_D_I]     = D_I_I;
  assign in_w[SEL_Q_I]     = Q_I_I;
  assign in_w[SEL_D_V]     = D_V_I;

  // write port never reaches storage; only LOAD_I updates words
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_obs
      fobr_obs_reg u_reg (
        .CLK_I  (CLK_I),
        .RST_I  (RST_I),
        .load_i (LOAD_I[gi]),
        .data_i (in_w[gi]),
        .q_o    (obs_w[gi])
      );
    end
  endgenerate

  // ************************************************************
  // address decode
  // ************************************************************
  function automatic logic [SEL_W:0] decode(input logic [ADDR_W-1:0] a);
    logic [SEL_W:0] r;
    r = {1'b0, SEL_W'(0)};
    if (a == OFS_ALPHA_I) begin
      r = {1'b1, SEL_ALPHA_I};
    end else if (a == OFS_BETA_I) begin
      r = {1'b1, SEL_BETA_I};
    end else if (a == OFS_ALPHA_V) begin
      r = {1'b1, SEL_ALPHA_V};
    end else if (a == OFS_ALPHA_V + OFS_STEP) begin
      r = {1'b1, SEL_BETA_V};
    end else if (a == OFS_D_I) begin
      r = {1'b1, SEL_D_I};
    end else if (a == OFS_D_I + OFS_STEP) begin
      r = {1'b1, SEL_Q_I};
    end else if (a == OFS_D_I + OFS_STEP + OFS_STEP) begin
      r = {1'b1, SEL_D_V};
    end
    return r;
  endfunction

  // ************************************************************
  // read port
  // ************************************************************
  logic [SEL_W:0]    dec_w;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic              rvalid_r;
  logic              rvalid_nxt;
  logic              hit_r;
  logic              hit_nxt;

  assign dec_w = decode(ADDR_I);

  always_comb begin
    rdata_nxt  = rdata_r;
    rvalid_nxt = RD_I;
    hit_nxt    = hit_r;
    if (RD_I) begin
      hit_nxt   = dec_w[SEL_W];
      rdata_nxt = dec_w[SEL_W] ? obs_w[dec_w[SEL_W-1:0]] : UNMAPPED;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      rdata_r  <= RST_VAL;
      rvalid_r <= 1'b0;
      hit_r    <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      hit_r    <= hit_nxt;
    end
  end

  assign RDATA_O  = rdata_r;
  assign RVALID_O = rvalid_r;
  assign HIT_O    = hit_r;

  // ************************************************************
  // read port checks
  // ************************************************************
  // the answer carries the word as it stood at the request edge, hence $past
  chk_read_latency: assert property (@(posedge CLK_I) disable iff (RST_I)
    RD_I |=> RVALID_O)
    else $error("read not answered next cycle");
  chk_valid_drop: assert property (@(posedge CLK_I) disable iff (RST_I)
    !RD_I |=> !RVALID_O)
    else $error("read valid without request");
  chk_read_hold: assert property (@(posedge CLK_I) disable iff (RST_I)
    !RD_I |=> $stable(RDATA_O) && $stable(HIT_O))
    else $error("read data moved without request");
  chk_alpha_i_read: assert property (@(posedge CLK_I) disable iff (RST_I)
    RD_I && ADDR_I == OFS_ALPHA_I
    |=> HIT_O && RDATA_O == $past(obs_w[SEL_ALPHA_I]))
    else $error("alpha current read wrong");
  chk_beta_i_read: assert property (@(posedge CLK_I) disable iff (RST_I)
    RD_I && ADDR_I == OFS_BETA_I
    |=> HIT_O && RDATA_O == $past(obs_w[SEL_BETA_I]))
    else $error("beta current read wrong");
  chk_alpha_v_read: assert property (@(posedge CLK_I) disable iff (RST_I)
    RD_I && ADDR_I == OFS_ALPHA_V
    |=> HIT_O && RDATA_O == $past(obs_w[SEL_ALPHA_V]))
    else $error("alpha voltage read wrong");
  chk_beta_v_addr: assert property (@(posedge CLK_I) disable iff (RST_I)
    RD_I && ADDR_I == OFS_BETA_V
    |=> HIT_O && RDATA_O == $past(obs_w[SEL_BETA_V]))
    else $error("beta voltage address wrong");
  chk_d_i_read: assert property (@(posedge CLK_I) disable iff (RST_I)
    RD_I && ADDR_I == OFS_D_I
    |=> HIT_O && RDATA_O == $past(obs_w[SEL_D_I]))
    else $error("d current read wrong");
  chk_q_i_read: assert property (@(posedge CLK_I) disable iff (RST_I)
    RD_I && ADDR_I == OFS_Q_I
    |=> HIT_O && RDATA_O == $past(obs_w[SEL_Q_I]))
    else $error("q current read wrong");
  chk_dv_addr: assert property (@(posedge CLK_I) disable iff (RST_I)
    RD_I && ADDR_I == OFS_D_V
    |=> HIT_O && RDATA_O == $past(obs_w[SEL_D_V]))
    else $error("d voltage address wrong");
  chk_mapped_hit: assert property (@(posedge CLK_I) disable iff (RST_I)
    RD_I && dec_w[SEL_W] |=> HIT_O)
    else $error("mapped read not flagged");
  chk_unmapped_zero: assert property (@(posedge CLK_I) disable iff (RST_I)
    RD_I && !dec_w[SEL_W]
    |=> !HIT_O && RDATA_O == UNMAPPED)
    else $error("unmapped read not zero");
  // odd offsets fall between words and must never alias one
  chk_odd_unmapped: assert property (@(posedge CLK_I) disable iff (RST_I)
    RD_I && ADDR_I[0]
    |=> !HIT_O && RDATA_O == UNMAPPED)
    else $error("odd offset read as a word");
  chk_reset_zero: assert property (@(posedge CLK_I)
    RST_I |=> RDATA_O == RST_VAL && !RVALID_O && !HIT_O)
    else $error("read port not cleared by reset");

  // ************************************************************
  // storage checks
  // ************************************************************
  chk_load_stores: assert property (@(posedge CLK_I) disable iff (RST_I)
    LOAD_I[SEL_Q_I]
    |=> obs_w[SEL_Q_I] == $past(Q_I_I))
    else $error("q current not loaded");
  chk_write_ignored: assert property (@(posedge CLK_I) disable iff (RST_I)
    WR_I && !LOAD_I[SEL_D_I]
    |=> $stable(obs_w[SEL_D_I]))
    else $error("write changed observation word");
  chk_wdata_unseen: assert property (@(posedge CLK_I) disable iff (RST_I)
    WR_I && !LOAD_I[SEL_ALPHA_I] && WDATA_I != obs_w[SEL_ALPHA_I]
    |=> obs_w[SEL_ALPHA_I] != $past(WDATA_I))
    else $error("write data reached a word");
  // every word: cleared by reset, loaded whole, otherwise frozen
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_chk
      chk_word_reset: assert property (@(posedge CLK_I)
        RST_I |=> obs_w[gi] == RST_VAL)
        else $error("word not zero after reset");
      chk_word_load: assert property (@(posedge CLK_I) disable iff (RST_I)
        LOAD_I[gi] |=> obs_w[gi] == $past(in_w[gi]))
        else $error("loaded word not stored whole");
      chk_word_hold: assert property (@(posedge CLK_I) disable iff (RST_I)
        !LOAD_I[gi] |=> $stable(obs_w[gi]))
        else $error("word changed without load");
    end
  endgenerate

  // ************************************************************
  // coverage
  // ************************************************************
  cov_read_hit: cover property (@(posedge CLK_I) disable iff (RST_I) RD_I && dec_w[SEL_W]);
  cov_read_miss: cover property (@(posedge CLK_I) disable iff (RST_I) RD_I && !dec_w[SEL_W]);
  cov_write_try: cover property (@(posedge CLK_I) disable iff (RST_I) WR_I);
  cov_load_read: cover property (@(posedge CLK_I) disable iff (RST_I)
    LOAD_I[SEL_D_I] ##1 RD_I && ADDR_I == OFS_D_I);
  cov_neg_read: cover property (@(posedge CLK_I) disable iff (RST_I)
    RVALID_O && HIT_O && RDATA_O[DATA_W-1]);
endmodule

// ===== fobr_obs_bank_test.sv
// self-checking bench for the observation register bank
`timescale 1ns/1ps
module fobr_obs_bank_test;
  import fobr_pkg::*;
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
  logic                CLK_I = 1'b0;
  logic                RST_I = 1'b1;
  logic [NUM_REGS-1:0] LOAD_I = '0;
  logic [DATA_W-1:0]   dat [NUM_REGS];
  logic                RD_I = 1'b0;
  logic                WR_I = 1'b0;
  logic [ADDR_W-1:0]   ADDR_I = '0;
  logic [DATA_W-1:0]   WDATA_I = '0;
  logic [DATA_W-1:0]   RDATA_O;
  logic                RVALID_O;
  logic                HIT_O;
  int                  error_cnt = 0;
  int                  num_checks = 0;
  int                  cyc = 0;
  logic [ADDR_W-1:0]   ofs [NUM_REGS];
  logic [DATA_W-1:0]   val [NUM_REGS];

  fobr_obs_bank uut (.CLK_I(CLK_I), .RST_I(RST_I), .LOAD_I(LOAD_I), .ALPHA_I_I(dat[0]),
    .BETA_I_I(dat[1]), .ALPHA_V_I(dat[2]), .BETA_V_I(dat[3]), .D_I_I(dat[4]), .Q_I_I(dat[5]),
    .D_V_I(dat[6]), .RD_I(RD_I), .WR_I(WR_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .RDATA_O(RDATA_O), .RVALID_O(RVALID_O), .HIT_O(HIT_O));

  initial forever #2.5 CLK_I = ~CLK_I;

  task automatic results();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // single read; valid must have dropped since the last one
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input logic h);
    @(negedge CLK_I);
    `CHK(RVALID_O, 1'b0)
    RD_I = 1'b1;
    ADDR_I = a;
    @(negedge CLK_I);
    RD_I = 1'b0;
    `CHK(RVALID_O, 1'b1)
    `CHK(HIT_O, h)
    `CHK(RDATA_O, e)
  endtask

  // ********************
  // tests
  // ********************
  initial begin
    foreach (dat[i]) dat[i] = '0;
    ofs = '{12'h4d2, 12'h4d4, 12'h4d6, 12'h4d8, 12'h4e2, 12'h4e4, 12'h4e6};
    val = '{32'h8000_0000, 32'hf800_0000, 32'h0800_0000, 32'hffff_ffff,
            32'h7fff_ffff, 32'h0000_0001, 32'hc000_0001};
    repeat (4) @(negedge CLK_I);
    RST_I = 1'b0;
    for (int i = 0; i < NUM_REGS; i++) rd(ofs[i], 32'h0, 1'b1);
    $display("test reset_values done");
    for (int i = 0; i < NUM_REGS; i++) begin
      @(negedge CLK_I);
      dat[i] = val[i];
      LOAD_I = 7'h01 << i;
      @(negedge CLK_I);
      LOAD_I = '0;
      dat[i] = ~val[i];
    end
    for (int i = 0; i < NUM_REGS; i++) rd(ofs[i], val[i], 1'b1);
    $display("test table done");
    for (int i = 0; i < NUM_REGS; i++) begin
      @(negedge CLK_I);
      WR_I = 1'b1;
      ADDR_I = ofs[i];
      WDATA_I = ~val[i];
    end
    @(negedge CLK_I);
    WR_I = 1'b0;
    for (int i = 0; i < NUM_REGS; i++) rd(ofs[i], val[i], 1'b1);
    $display("test writes_ignored done");
    rd(12'h4d3, 32'h0, 1'b0);
    rd(12'h4e8, 32'h0, 1'b0);
    $display("test unmapped done");
    // read and load of one word in the same cycle returns the old value
    @(negedge CLK_I);
    RD_I = 1'b1;
    ADDR_I = 12'h4e4;
    LOAD_I = 7'h20;
    dat[5] = 32'h9000_0000;
    @(negedge CLK_I);
    RD_I = 1'b0;
    LOAD_I = '0;
    `CHK(RDATA_O, val[5])
    rd(12'h4e4, 32'h9000_0000, 1'b1);
    $display("test read_load_clash done");
    @(negedge CLK_I);
    RST_I = 1'b1;
    @(negedge CLK_I);
    RST_I = 1'b0;
    for (int i = 0; i < NUM_REGS; i++) rd(ofs[i], 32'h0, 1'b1);
    $display("test second_reset done");
    results();
  end

  always @(posedge CLK_I) begin
    cyc <= cyc + 1;
    if (cyc > 2000) begin
      error_cnt++;
      results();
    end
  end
endmodule
